// *** shared/can_filt_pkg.sv ***
package can_filt_pkg;

   // ------------------------------------------------------------
   // Register map, byte addresses on the AHB-Lite word grid
   // ------------------------------------------------------------
   localparam logic [31:0] ADDR_ACC_BASE  = 32'h0000_0000; // Acceptance codes 0..7
   localparam logic [31:0] ADDR_MASK_BASE = 32'h0000_0020; // Don't-care masks 0..7
   localparam logic [31:0] ADDR_CTRL      = 32'h0000_0040; // Filter mode select
   localparam logic [31:0] ADDR_STAT      = 32'h0000_0044; // Hit index, foreground state
   localparam logic [31:0] ADDR_FGID_BASE = 32'h0000_0048; // Foreground identifier 0..3
   localparam logic [31:0] ADDR_FGID_LAST = 32'h0000_0054; // Last identifier register

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CTRL_MODE_LSB   = 0;  // Two-bit mode field
   localparam int STAT_HIT_LSB    = 0;  // Three-bit hit index
   localparam int STAT_FGV_BIT    = 8;  // Foreground holds a message
   localparam int STAT_REL_BIT    = 8;  // Write one here to release it
   localparam int STAT_DROP_BIT   = 9;  // Sticky: a message was discarded

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] ACC_RST  = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;

   // ------------------------------------------------------------
   // Bus constants
   // ------------------------------------------------------------
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;
   localparam logic       HRESP_OKAY    = 1'h0;

   // Filter groupings, in register encoding order
   typedef enum logic [1:0] {
      MODE_32,
      MODE_16,
      MODE_8,
      MODE_CLOSED
   } filt_mode_t;

   // Reset grouping: nothing gets through until software opens it
   localparam filt_mode_t MODE_RST = MODE_CLOSED;

   // Bus slave phase tracking
   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_WR,
      BUS_RD_WAIT,
      BUS_RD_OUT
   } bus_state_t;

   // Identifier bytes as the receiver lays them out
   typedef struct packed {
      logic [7:0] b0;  // Top identifier bits
      logic [7:0] b1;  // Next bits plus control flags
      logic [7:0] b2;  // Extended only
      logic [7:0] b3;  // Extended only, remote flag in bit 0
   } rx_id_t;

   // Latched address phase
   typedef struct packed {
      logic        wr;
      logic [31:0] addr;
   } ahb_phase_t;

endpackage

// *** hdl/can_rx_id_acceptance_filter.sv ***
`timescale 1ns/1ps
`default_nettype none

module can_rx_id_acceptance_filter #(
   parameter int NUM_PAIRS = 8   // Mask/code pairs
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  srst,
   // AHB-Lite slave
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic [31:0]                hrdata,
   // Message from the bit-stream receiver
   input  wire logic                  rx_msg_valid,
   input  wire can_filt_pkg::rx_id_t  rx_msg_id,
   // Toward receive flag logic
   output logic                       rx_fg_valid,
   output logic [2:0]                 rx_fg_hit,
   output logic                       rx_drop
);

   // ------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------
   // Groupings are hard-wired to eight pairs
   if (NUM_PAIRS != 8)
   begin : g_bad_pairs
      $error("NUM_PAIRS must be 8");
   end

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   // One byte compare; set mask bits exclude a position
   function automatic logic byte_hit(input logic [7:0] id,
                                     input logic [7:0] code,
                                     input logic [7:0] mask);
      byte_hit = ((id ^ code) & ~mask) == 8'h00;
   endfunction

   // Lowest set bit wins, as the filters are checked in order
   function automatic logic [2:0] first_hit(input logic [7:0] v);
      first_hit = 3'h0;
      for (int i = 7; i >= 0; i--)
      begin
         if (v[i])
         begin
            first_hit = 3'(i);
         end
      end
   endfunction

   // Word-aligned, in-range test for a region of registers
   function automatic logic in_region(input logic [31:0] a,
                                      input logic [31:0] base,
                                      input logic [31:0] last);
      in_region = (a >= base) && (a <= last) && (a[1:0] == 2'h0);
   endfunction

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [7:0]               acc_ff  [8];   // Acceptance codes
   logic [7:0]               mask_ff [8];   // Don't-care masks, set bits excluded
   can_filt_pkg::filt_mode_t mode_ff;       // Filter grouping
   can_filt_pkg::rx_id_t     bg_id_ff;      // Background buffer
   logic                     bg_valid_ff;   // Background occupied
   can_filt_pkg::rx_id_t     fg_id_ff;      // Foreground buffer
   logic                     fg_valid_ff;   // Foreground occupied
   logic [2:0]               fg_hit_ff;     // Hit index of foreground
   logic                     drop_ff;       // Discard pulse
   logic                     drop_seen_ff;  // Sticky discard flag
   can_filt_pkg::bus_state_t bus_st_ff;     // Bus phase state
   can_filt_pkg::ahb_phase_t phase_ff;      // Latched address phase
   logic [31:0]              hrdata_ff;     // Read data

   // ------------------------------------------------------------
   // Filtering of the background message
   // ------------------------------------------------------------
   logic [7:0] pair_match;   // Each pair against its own byte
   logic [7:0] hit_vec;      // Hits after grouping
   logic       accepted;     // Any filter hit
   logic [2:0] hit_idx;      // Winning filter number

   // Pair k looks at byte k mod 4, k mod 2 or byte 0 by mode
   for (genvar k = 0; k < 8; k++)
   begin : g_pair
      logic [7:0] id_byte;
      logic [7:0] byte_sel;
      assign byte_sel = (k % 4 == 0) ? bg_id_ff.b0 :
                        (k % 4 == 1) ? bg_id_ff.b1 :
                        (k % 4 == 2) ? bg_id_ff.b2 : bg_id_ff.b3;
      assign id_byte  = (mode_ff == can_filt_pkg::MODE_32) ? byte_sel :
                        (mode_ff == can_filt_pkg::MODE_16) ?
                        ((k % 2 == 0) ? bg_id_ff.b0 : bg_id_ff.b1) :
                        bg_id_ff.b0;
      assign pair_match[k] = byte_hit(id_byte, acc_ff[k], mask_ff[k]);
   end

   // Grouping of pair results into filters
   assign hit_vec =
      (mode_ff == can_filt_pkg::MODE_32) ?
         {6'h00, &pair_match[7:4], &pair_match[3:0]} :
      (mode_ff == can_filt_pkg::MODE_16) ?
         {4'h0, &pair_match[7:6], &pair_match[5:4],
          &pair_match[3:2], &pair_match[1:0]} :
      (mode_ff == can_filt_pkg::MODE_8) ? pair_match :
      8'h00;

   assign accepted = |hit_vec;
   assign hit_idx  = first_hit(hit_vec);

   // ------------------------------------------------------------
   // Buffer chain control
   // ------------------------------------------------------------
   logic fg_release;   // Software frees the foreground
   logic fg_free;      // Foreground can take a message
   logic do_shift;     // Background moves to foreground
   logic do_drop;      // Background message rejected
   logic stat_wr;      // Data phase write to status register

   assign fg_free  = ~fg_valid_ff | fg_release;
   // An accepted message waits in the background while the
   // foreground is still owned by software
   assign do_shift = bg_valid_ff & accepted & fg_free;
   assign do_drop  = bg_valid_ff & ~accepted;

   // Background: every message lands here first; a new arrival
   // always overwrites, so an accepted one still waiting on the foreground is simply replaced
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         bg_valid_ff <= 1'b0;
         bg_id_ff    <= '0;
      end
      else
      begin
         if (rx_msg_valid)
         begin
            bg_id_ff    <= rx_msg_id;
            bg_valid_ff <= 1'b1;
         end
         else if (do_shift | do_drop)
         begin
            bg_valid_ff <= 1'b0;
         end
      end
   end

   // Foreground: id and hit index move together so the index
   // never describes any other message
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         fg_valid_ff <= 1'b0;
         fg_id_ff    <= '0;
         fg_hit_ff   <= 3'h0;
      end
      else
      begin
         if (do_shift)
         begin
            fg_id_ff    <= bg_id_ff;
            fg_hit_ff   <= hit_idx;
            fg_valid_ff <= 1'b1;
         end
         else if (fg_release)
         begin
            fg_valid_ff <= 1'b0;
         end
      end
   end

   // Discard reporting; a new discard beats a clear
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         drop_ff      <= 1'b0;
         drop_seen_ff <= 1'b0;
      end
      else
      begin
         drop_ff <= do_drop;
         if (do_drop)
         begin
            drop_seen_ff <= 1'b1;
         end
         else if (stat_wr && hwdata[can_filt_pkg::STAT_DROP_BIT])
         begin
            drop_seen_ff <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // AHB-Lite slave
   // ------------------------------------------------------------
   logic addr_take;   // Address phase accepted this edge
   logic acc_wr;      // Data phase write to a code register
   logic mask_wr;     // Data phase write to a mask register
   logic ctrl_wr;     // Data phase write to mode register
   logic [2:0] wr_idx;    // Pair index of the write
   logic [31:0] rd_word;  // Read mux output

   assign addr_take = hsel & htrans[1] & hready;
   assign wr_idx    = phase_ff.addr[4:2];
   assign acc_wr  = (bus_st_ff == can_filt_pkg::BUS_WR) &
                    in_region(phase_ff.addr, can_filt_pkg::ADDR_ACC_BASE,
                              can_filt_pkg::ADDR_MASK_BASE - 32'h4);
   assign mask_wr = (bus_st_ff == can_filt_pkg::BUS_WR) &
                    in_region(phase_ff.addr, can_filt_pkg::ADDR_MASK_BASE,
                              can_filt_pkg::ADDR_CTRL - 32'h4);
   assign ctrl_wr = (bus_st_ff == can_filt_pkg::BUS_WR) &
                    (phase_ff.addr == can_filt_pkg::ADDR_CTRL);
   assign stat_wr = (bus_st_ff == can_filt_pkg::BUS_WR) &
                    (phase_ff.addr == can_filt_pkg::ADDR_STAT);
   assign fg_release = stat_wr & hwdata[can_filt_pkg::STAT_REL_BIT];

   // Read mux over the latched address; unmapped reads as zero
   function automatic logic [31:0] reg_read(input logic [31:0] a);
      logic [2:0] i;
      i = a[4:2];
      reg_read = 32'h0000_0000;
      if (in_region(a, can_filt_pkg::ADDR_ACC_BASE, can_filt_pkg::ADDR_MASK_BASE - 32'h4))
      begin
         reg_read = {24'h000000, acc_ff[i]};
      end
      else if (in_region(a, can_filt_pkg::ADDR_MASK_BASE, can_filt_pkg::ADDR_CTRL - 32'h4))
      begin
         reg_read = {24'h000000, mask_ff[i]};
      end
      else if (a == can_filt_pkg::ADDR_CTRL)
      begin
         reg_read[can_filt_pkg::CTRL_MODE_LSB +: 2] = mode_ff;
      end
      else if (a == can_filt_pkg::ADDR_STAT)
      begin
         reg_read[can_filt_pkg::STAT_HIT_LSB +: 3] = fg_hit_ff;
         reg_read[can_filt_pkg::STAT_FGV_BIT]      = fg_valid_ff;
         reg_read[can_filt_pkg::STAT_DROP_BIT]     = drop_seen_ff;
      end
      else if (in_region(a, can_filt_pkg::ADDR_FGID_BASE, can_filt_pkg::ADDR_FGID_LAST))
      begin
         // Standard messages use only the first two of these
         unique case (a[3:2])
            2'h2:    reg_read = {24'h000000, fg_id_ff.b0};
            2'h3:    reg_read = {24'h000000, fg_id_ff.b1};
            2'h0:    reg_read = {24'h000000, fg_id_ff.b2};
            default: reg_read = {24'h000000, fg_id_ff.b3};
         endcase
      end
   endfunction

   // A process rather than an assign, so a register write also
   // refreshes the mux while the latched address stays the same
   always_comb
   begin
      rd_word = reg_read(phase_ff.addr);
   end

   // Bus phase sequencing; reads take one wait state so the
   // data leaves a flip-flop and sees any write just before
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         bus_st_ff <= can_filt_pkg::BUS_IDLE;
         phase_ff  <= '0;
      end
      else
      begin
         unique case (bus_st_ff)
            can_filt_pkg::BUS_RD_WAIT:
            begin
               bus_st_ff <= can_filt_pkg::BUS_RD_OUT;
            end
            default:
            begin
               // Idle, write data phase or read output: open
               if (addr_take)
               begin
                  phase_ff.addr <= haddr;
                  phase_ff.wr   <= hwrite;
                  bus_st_ff     <= hwrite ? can_filt_pkg::BUS_WR
                                          : can_filt_pkg::BUS_RD_WAIT;
               end
               else
               begin
                  bus_st_ff <= can_filt_pkg::BUS_IDLE;
               end
            end
         endcase
      end
   end

   // Read data register
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         hrdata_ff <= 32'h0000_0000;
      end
      else if (bus_st_ff == can_filt_pkg::BUS_RD_WAIT)
      begin
         hrdata_ff <= rd_word;
      end
   end

   // ------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------
   // Codes and masks, low byte of the write data
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         for (int p = 0; p < 8; p++)
         begin
            acc_ff[p]  <= can_filt_pkg::ACC_RST;
            mask_ff[p] <= can_filt_pkg::MASK_RST;
         end
      end
      else
      begin
         if (acc_wr)
         begin
            acc_ff[wr_idx] <= hwdata[7:0];
         end
         if (mask_wr)
         begin
            mask_ff[wr_idx] <= hwdata[7:0];
         end
      end
   end

   // Mode select; changing it while traffic flows gives a
   // message filtered under either grouping, hence set it first
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         mode_ff <= can_filt_pkg::MODE_RST;
      end
      else if (ctrl_wr)
      begin
         mode_ff <= can_filt_pkg::filt_mode_t'(
                       hwdata[can_filt_pkg::CTRL_MODE_LSB +: 2]);
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign hreadyout   = (bus_st_ff != can_filt_pkg::BUS_RD_WAIT);
   assign hresp       = can_filt_pkg::HRESP_OKAY;
   assign hrdata      = hrdata_ff;
   assign rx_fg_valid = fg_valid_ff;
   assign rx_fg_hit   = fg_hit_ff;
   assign rx_drop     = drop_ff;

endmodule

`default_nettype wire

// *** verif/can_filt_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checks of the acceptance filter
// ------------------------------------------------------------
module can_filt_asserts (
   // Clock and reset
   input wire logic       clk,
   input wire logic       srst,
   // Bus
   input wire logic       hsel,
   input wire logic [1:0] htrans,
   input wire logic       hwrite,
   input wire logic       hready,
   input wire logic       hreadyout,
   input wire logic       hresp,
   // Receive path
   input wire logic       rx_msg_valid,
   input wire logic       rx_fg_valid,
   input wire logic [2:0] rx_fg_hit,
   input wire logic       rx_drop
);
   wire  taken = hsel && htrans[1] && hready; // Address phase accepted
   logic wr_dp_ff;                            // Write data phase, may release foreground
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // Writes excuse foreground changes one edge later
   always_ff @(posedge clk)
      if (srst)
         wr_dp_ff <= 1'b0;
      else
         wr_dp_ff <= taken && hwrite;
   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
   property p_rd_wait; taken && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
   property p_wr_fast; taken && hwrite |=> hreadyout; endproperty
   a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
   property p_hit_hold; rx_fg_valid && !wr_dp_ff |=> $stable(rx_fg_hit); endproperty
   a_hit_hold: assert property (p_hit_hold) else $error("hit index moved");
   property p_fg_hold; rx_fg_valid && !wr_dp_ff |=> rx_fg_valid; endproperty
   a_fg_hold: assert property (p_fg_hold) else $error("foreground lost");
   property p_rise_src; $rose(rx_fg_valid) |-> $past(rx_msg_valid, 2); endproperty
   a_rise_src: assert property (p_rise_src) else $error("shift without message");
   property p_drop_src;
      rx_drop |-> $past(rx_msg_valid, 2) || $past(wr_dp_ff) || $past(wr_dp_ff, 2);
   endproperty
   a_drop_src: assert property (p_drop_src) else $error("drop without message");
   sequence s_lone_msg;
      rx_msg_valid && !rx_fg_valid ##1 !rx_msg_valid && !rx_fg_valid && !wr_dp_ff;
   endsequence
   property p_outcome; s_lone_msg |=> rx_fg_valid || rx_drop; endproperty
   a_outcome: assert property (p_outcome) else $error("message had no outcome");
   // Main scenarios reached
   c_read: cover property (taken && !hwrite);
   c_accept: cover property ($rose(rx_fg_valid));
   c_drop: cover property (rx_drop);
   c_hit7: cover property (rx_fg_valid && rx_fg_hit == 3'h7);
endmodule
`default_nettype wire

// *** verif/can_rx_source_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Bit-stream receiver stand-in
// ------------------------------------------------------------
module can_rx_source_model (
   // Clock
   input wire logic                 clk,
   // Message toward the filter
   output var logic                 rx_msg_valid,
   output var can_filt_pkg::rx_id_t rx_msg_id
);
   // Idle line starts at zero, then shows the inverse of the last message so stale bytes never look valid
   initial
   begin
      rx_msg_valid = 1'b0;
      rx_msg_id    = '0;
   end
   // One-cycle message pulse
   task automatic send(input can_filt_pkg::rx_id_t id);
      @(posedge clk);
      rx_msg_valid <= 1'b1;
      rx_msg_id    <= id;
      @(posedge clk);
      rx_msg_valid <= 1'b0;
      rx_msg_id    <= ~id;
   endtask
   // Two messages on consecutive edges
   task automatic send_pair(input can_filt_pkg::rx_id_t a, input can_filt_pkg::rx_id_t b);
      @(posedge clk);
      rx_msg_valid <= 1'b1;
      rx_msg_id    <= a;
      @(posedge clk);
      rx_msg_id    <= b;
      @(posedge clk);
      rx_msg_valid <= 1'b0;
      rx_msg_id    <= ~b;
   endtask
endmodule
`default_nettype wire

// *** verif/tb_can_rx_id_acceptance_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_can_rx_id_acceptance_filter;
   logic        clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, v;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h0;
   logic [28:0] r;
   wire logic   hreadyout, hresp, rx_msg_valid, rx_fg_valid, rx_drop;
   wire logic [31:0] hrdata;
   wire logic [2:0]  rx_fg_hit;
   wire can_filt_pkg::rx_id_t rx_msg_id;
   int          failures = 0, n_checks = 0, cyc = 0;
   logic [3:0]  mq[$];          // Expected outcome: bit3 drop, else hit index
   bit          fg_taken = 1'b0; // Foreground already compared
   always #20 clk = ~clk;
   // ------------------------------------------------------------
   // Design and partner
   // ------------------------------------------------------------
   can_rx_id_acceptance_filter DUT (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_msg_valid(rx_msg_valid),
      .rx_msg_id(rx_msg_id), .rx_fg_valid(rx_fg_valid), .rx_fg_hit(rx_fg_hit),
      .rx_drop(rx_drop));
   can_rx_source_model src (.clk(clk), .rx_msg_valid(rx_msg_valid), .rx_msg_id(rx_msg_id));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic can_filt_pkg::rx_id_t ext(input logic [28:0] id, input logic rtr);
      return {id[28:21], id[20:18], 2'b11, id[17:15], id[14:7], id[6:0], rtr};
   endfunction
   // Standard layout; trailing bytes random since they are unused
   function automatic can_filt_pkg::rx_id_t std(input logic [10:0] id, input logic rtr);
      return {id[10:3], id[2:0], rtr, 4'h0, 16'($urandom)};
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Single AHB-Lite transfer, waits on hready in both phases
   task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
      @(posedge clk);
      hsel <= 1'b1; haddr <= a; hwrite <= w;
      htrans <= can_filt_pkg::HTRANS_NONSEQ; hsize <= can_filt_pkg::HSIZE_WORD;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [31:0] a, exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q, exp);
   endtask
   // Load n consecutive pairs from packed code and mask words
   task automatic setf(input int p, n, input logic [31:0] c, m);
      for (int k = 0; k < n; k++)
      begin
         wr(can_filt_pkg::ADDR_ACC_BASE + 32'(4 * (p + k)), 32'(c[31 - 8 * k -: 8]));
         wr(can_filt_pkg::ADDR_MASK_BASE + 32'(4 * (p + k)), 32'(m[31 - 8 * k -: 8]));
      end
   endtask
   // Release foreground and clear the sticky drop flag
   task automatic rel;
      wr(can_filt_pkg::ADDR_STAT, 32'h300);
      fg_taken = 1'b0;
   endtask
   task automatic msg(input can_filt_pkg::rx_id_t id, input logic [3:0] e);
      mq.push_back(e);
      src.send(id);
      repeat (3) @(posedge clk);
      if (!e[3])
         rel();
   endtask
   task automatic pop(input logic [3:0] got);
      if (mq.size() == 0)
         check({28'h0, got}, 32'hff);
      else
         check({28'h0, got}, {28'h0, mq.pop_front()});
   endtask
   task automatic summarize;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Outcome watcher, sampled mid-cycle where outputs are settled
   always @(negedge clk)
      if (!srst)
      begin
         if (rx_drop === 1'b1)
            pop(4'h8);
         if (rx_fg_valid === 1'b1 && !fg_taken)
         begin
            fg_taken = 1'b1;
            pop({1'b0, rx_fg_hit});
         end
      end
   // Hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         summarize();
      end
   end
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial
   begin
      void'($urandom(32'h6cd6));
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      // Reset values, unmapped place
      rd(can_filt_pkg::ADDR_ACC_BASE, {24'h0, can_filt_pkg::ACC_RST});
      rd(can_filt_pkg::ADDR_MASK_BASE + 32'h1c, {24'h0, can_filt_pkg::MASK_RST});
      rd(can_filt_pkg::ADDR_CTRL, 32'(can_filt_pkg::MODE_RST));
      rd(can_filt_pkg::ADDR_STAT, 32'h0);
      rd(32'h0000_0060, 32'h0);
      // All sixteen registers take random bytes, upper bits read zero
      for (int k = 0; k < 16; k++)
      begin
         v = $urandom;
         wr(can_filt_pkg::ADDR_ACC_BASE + 32'(4 * k), v);
         rd(can_filt_pkg::ADDR_ACC_BASE + 32'(4 * k), v & 32'hff);
      end
      msg(ext(29'($urandom), 1'b0), 4'h8);
      // Two wide filters, low two identifier bits free in filter 0
      wr(can_filt_pkg::ADDR_CTRL, 32'(can_filt_pkg::MODE_32));
      r = 29'($urandom) | 29'h1000_0000;
      setf(0, 4, ext(29'h801, 1'b0), 32'h6);
      setf(4, 4, ext(r, 1'b0), 32'h0);
      msg(ext(29'h801, 1'b0), 4'h0);
      msg(ext(29'h802, 1'b0), 4'h0);
      msg(ext(29'h805, 1'b0), 4'h8);
      msg(ext(29'h801, 1'b1), 4'h8);
      msg(ext(r, 1'b0), 4'h1);
      setf(4, 4, ext(29'h801, 1'b0), 32'h6);
      msg(ext(29'h802, 1'b0), 4'h0);
      // Four half-width filters, trailing bytes random
      wr(can_filt_pkg::ADDR_CTRL, 32'(can_filt_pkg::MODE_16));
      for (int f = 0; f < 4; f++)
      begin
         v = {8'(8'h10 + f), 8'h18, 16'h0};
         setf(2 * f, 2, v, 32'h0);
         msg({v[31:16], 16'($urandom)}, 4'(f));
      end
      setf(6, 2, std(11'h321, 1'b0), 32'h0060_0000);
      msg(std(11'h322, 1'b0), 4'h3);
      msg(std(11'h321, 1'b1), 4'h8);
      msg(std(11'h324, 1'b0), 4'h8);
      // Eight byte filters on the top byte only
      wr(can_filt_pkg::ADDR_CTRL, 32'(can_filt_pkg::MODE_8));
      for (int k = 0; k < 8; k++)
      begin
         setf(k, 1, {8'(8'ha0 + k), 24'h0}, 32'h0);
         msg({8'(8'ha0 + k), 24'($urandom)}, 4'(k));
      end
      msg({8'h55, 24'($urandom)}, 4'h8);
      wr(can_filt_pkg::ADDR_MASK_BASE + 32'h1c, 32'hff);
      msg({8'h55, 24'($urandom)}, 4'h7);
      // Arrivals while foreground busy: last accepted one wins
      mq.push_back(4'h0);
      src.send({8'ha0, 24'h0});
      repeat (3) @(posedge clk);
      rd(can_filt_pkg::ADDR_STAT, 32'h100);
      rd(can_filt_pkg::ADDR_FGID_BASE, 32'ha0);
      mq.push_back(4'h2);
      src.send_pair({8'ha1, 24'h0}, {8'ha2, 24'h0});
      repeat (3) @(posedge clk);
      rel();
      rd(can_filt_pkg::ADDR_STAT, 32'h102);
      rel();
      wr(can_filt_pkg::ADDR_CTRL, 32'(can_filt_pkg::MODE_CLOSED));
      msg(ext(29'h801, 1'b0), 4'h8);
      repeat (4) @(posedge clk);
      check(32'(mq.size()), 32'h0);
      summarize();
   end
endmodule
bind can_rx_id_acceptance_filter can_filt_asserts u_chk (.clk(clk), .srst(srst), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .rx_msg_valid(rx_msg_valid), .rx_fg_valid(rx_fg_valid), .rx_fg_hit(rx_fg_hit),
   .rx_drop(rx_drop));
`default_nettype wire
